// ### push_pull_pkg.sv
`default_nettype none
// ****************************************************************
// Shared constants and types
// ****************************************************************
package push_pull_pkg;

  // Oscillator cycles with everything off after a fault
  localparam int RETRY_CYCLES    = 56;
  // Oscillator cycles of marker-only operation before the first gate pulse
  localparam int MARK_CYCLES     = 2;
  // Leading-edge modulated ramp cycles before full width
  localparam int SS_STEPS        = 5;
  // Oscillator cycles of one complete recovery
  localparam int RECOVERY_CYCLES = 64;
  // Width of the charge-phase length counter in mclk cycles
  localparam int CHG_W           = 16;
  // Width of the oscillator-cycle counters
  localparam int OSC_W           = 7;
  // Width of the ramp step counter
  localparam int RAMP_W          = 3;

  typedef enum logic [2:0] {
    ST_LOCKOUT,
    ST_WAIT,
    ST_MARK,
    ST_SOFT,
    ST_RUN
  } seq_state_t;

  typedef struct packed {
    logic discharge;
    logic current_limit;
    logic undervoltage_lockout;
  } sense_t;

endpackage : push_pull_pkg
`default_nettype wire

// ### sense_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Two-flop synchroniser for the comparator inputs
// ****************************************************************
module sense_sync (
  input  wire logic                 mclk,
  input  wire logic                 reset,
  input  wire push_pull_pkg::sense_t raw,
  output var  push_pull_pkg::sense_t synced
);

  localparam int NBITS = $bits(push_pull_pkg::sense_t);

  logic [NBITS-1:0] stage1;
  logic [NBITS-1:0] stage2;

  genvar i;
  generate
    for (i = 0; i < NBITS; i++) begin : g_bit
      always_ff @(posedge mclk) begin
        if (reset) begin
          stage1[i] <= 1'b0;
          stage2[i] <= 1'b0;
        end else begin
          stage1[i] <= raw[i];
          stage2[i] <= stage1[i];
        end
      end
    end
  endgenerate

  assign synced = stage2;

endmodule : sense_sync
`default_nettype wire

// ### push_pull_fault_sequencer.sv
// Contract
// - Pulses alternate between the gates via a toggle advanced once per oscillator cycle; the code advances it as each pulse ends.
// - Each gate output runs at half the oscillator rate.
// - While gating is active the marker is high exactly during the discharge phase.
// - While the sequencer waits or is locked out the marker is held low.
// - A current-limit assertion triggers an over-current shutdown ending output pulses.
// - After a fault at least 56 oscillator cycles pass with all outputs off before restart.
// - The first gate pulse comes 57 to 62 oscillator cycles after start, nominally 59.
// - Soft start lasts 4 to 7 output cycles, nominally 5, before the first full-width pulse.
// - Soft start widens pulses by moving the leading edge earlier each cycle.
// - Over-current kills both gates at once without finishing the pulse in progress.
// - Marker pulses resume at least one oscillator cycle before the first gate pulse.
// - A recovery spans 64 oscillator cycles: off, one or two marker pulses, then the ramp.
`timescale 1ns/1ps
`default_nettype none
module push_pull_fault_sequencer (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic discharge_phase_node,
  input  wire logic current_sense_trip,
  input  wire logic undervoltage_lockout,
  output logic      gate_drive_first,
  output logic      gate_drive_second,
  output logic      dead_time_marker
);

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  push_pull_pkg::sense_t raw;
  push_pull_pkg::sense_t sense;

  assign raw = '{discharge:            discharge_phase_node,
                 current_limit:        current_sense_trip,
                 undervoltage_lockout: undervoltage_lockout};

  sense_sync u_sync (
    .mclk   (mclk),
    .reset  (reset),
    .raw    (raw),
    .synced (sense)
  );

  // ****************************************************************
  // Sequencer state
  // ****************************************************************
  push_pull_pkg::seq_state_t            state;
  push_pull_pkg::seq_state_t            next_state;
  logic [push_pull_pkg::OSC_W-1:0]      osc_count;
  logic [push_pull_pkg::OSC_W-1:0]      next_osc_count;
  logic [push_pull_pkg::RAMP_W-1:0]     ramp;
  logic [push_pull_pkg::RAMP_W-1:0]     next_ramp;
  logic [push_pull_pkg::CHG_W-1:0]      chg_count;
  logic [push_pull_pkg::CHG_W-1:0]      next_chg_count;
  logic [push_pull_pkg::CHG_W-1:0]      last_chg;
  logic [push_pull_pkg::CHG_W-1:0]      next_last_chg;
  logic                                 dis_d;
  logic                                 sel;
  logic                                 next_sel;
  logic                                 next_first;
  logic                                 next_second;
  logic                                 next_marker;
  logic                                 osc_tick;
  logic                                 edge_ok;
  logic                                 gate_on;
  logic [push_pull_pkg::CHG_W+2:0]      elapsed_scaled;
  logic [push_pull_pkg::CHG_W+2:0]      blank_scaled;

  // One oscillator cycle ends as its discharge phase starts
  assign osc_tick = sense.discharge & ~dis_d;

  // Leading edge sits at ramp/(SS_STEPS+1) of the last charge phase
  assign elapsed_scaled = {3'h0, chg_count}
                        * (push_pull_pkg::CHG_W+3)'(push_pull_pkg::SS_STEPS + 1);
  assign blank_scaled   = {3'h0, last_chg}
                        * {{push_pull_pkg::CHG_W{1'b0}}, ramp};
  assign edge_ok        = elapsed_scaled >= blank_scaled;

  always_comb begin
    next_state     = state;
    next_osc_count = osc_count;
    next_ramp      = ramp;
    case (state)
      push_pull_pkg::ST_LOCKOUT: begin
        if (!sense.undervoltage_lockout) begin
          next_state     = push_pull_pkg::ST_WAIT;
          next_osc_count = '0;
        end
      end
      push_pull_pkg::ST_WAIT: begin
        if (sense.current_limit) begin
          next_osc_count = '0;
        end else if (osc_tick) begin
          if (osc_count == (push_pull_pkg::OSC_W)'(push_pull_pkg::RETRY_CYCLES - 1)) begin
            next_state     = push_pull_pkg::ST_MARK;
            next_osc_count = '0;
          end else begin
            next_osc_count = osc_count + 1'b1;
          end
        end
      end
      push_pull_pkg::ST_MARK: begin
        if (osc_tick) begin
          if (osc_count == (push_pull_pkg::OSC_W)'(push_pull_pkg::MARK_CYCLES - 1)) begin
            next_state = push_pull_pkg::ST_SOFT;
            next_ramp  = (push_pull_pkg::RAMP_W)'(push_pull_pkg::SS_STEPS);
          end else begin
            next_osc_count = osc_count + 1'b1;
          end
        end
      end
      push_pull_pkg::ST_SOFT: begin
        if (osc_tick) begin
          if (ramp == (push_pull_pkg::RAMP_W)'(1)) begin
            next_state = push_pull_pkg::ST_RUN;
          end else begin
            next_ramp = ramp - 1'b1;
          end
        end
      end
      push_pull_pkg::ST_RUN: begin
        next_state = state;
      end
      default: begin
        next_state = push_pull_pkg::ST_LOCKOUT;
      end
    endcase
    if (state != push_pull_pkg::ST_LOCKOUT && state != push_pull_pkg::ST_WAIT
        && sense.current_limit) begin
      next_state     = push_pull_pkg::ST_WAIT;
      next_osc_count = '0;
    end
    if (sense.undervoltage_lockout) begin
      next_state = push_pull_pkg::ST_LOCKOUT;
    end
  end

  // ****************************************************************
  // Charge-phase timing, toggle and outputs
  // ****************************************************************
  assign gate_on = ((state == push_pull_pkg::ST_SOFT) && edge_ok)
                 || (state == push_pull_pkg::ST_RUN);

  always_comb begin
    next_chg_count = chg_count;
    next_last_chg  = last_chg;
    next_sel       = sel;
    if (sense.discharge) begin
      next_chg_count = '0;
    end else if (chg_count != {push_pull_pkg::CHG_W{1'b1}}) begin
      next_chg_count = chg_count + 1'b1;
    end
    if (osc_tick) begin
      next_last_chg = chg_count;
    end
    // Fault inputs gate the next value directly so shutdown needs no tick
    next_first  = gate_on && !sense.discharge && !sense.current_limit
                && !sense.undervoltage_lockout && !sel;
    next_second = gate_on && !sense.discharge && !sense.current_limit
                && !sense.undervoltage_lockout && sel;
    // Toggle advances as each pulse ends, so a pulse cut short by a fault still counts
    if ((gate_drive_first || gate_drive_second) && !next_first && !next_second) begin
      next_sel = ~sel;
    end
    // Marker is armed only as a discharge phase starts and held to its end unless a fault clears it
    next_marker = sense.discharge && !sense.current_limit
                && !sense.undervoltage_lockout
                && (osc_tick ? (state == push_pull_pkg::ST_MARK
                                || state == push_pull_pkg::ST_SOFT
                                || state == push_pull_pkg::ST_RUN)
                             : dead_time_marker);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state             <= push_pull_pkg::ST_LOCKOUT;
      osc_count         <= '0;
      ramp              <= '0;
      chg_count         <= '0;
      last_chg          <= '0;
      dis_d             <= 1'b0;
      sel               <= 1'b0;
      gate_drive_first  <= 1'b0;
      gate_drive_second <= 1'b0;
      dead_time_marker  <= 1'b0;
    end else begin
      state             <= next_state;
      osc_count         <= next_osc_count;
      ramp              <= next_ramp;
      chg_count         <= next_chg_count;
      last_chg          <= next_last_chg;
      dis_d             <= sense.discharge;
      sel               <= next_sel;
      gate_drive_first  <= next_first;
      gate_drive_second <= next_second;
      dead_time_marker  <= next_marker;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic                            last_gate;
  logic [push_pull_pkg::OSC_W-1:0] rec_ticks;
  logic                            fault_now;

  assign fault_now = sense.current_limit || sense.undervoltage_lockout
                   || state == push_pull_pkg::ST_LOCKOUT;

  always_ff @(posedge mclk) begin
    if (reset) begin
      last_gate <= 1'b1;
      rec_ticks <= '0;
    end else begin
      if (gate_drive_first) begin
        last_gate <= 1'b0;
      end else if (gate_drive_second) begin
        last_gate <= 1'b1;
      end
      if (fault_now) begin
        rec_ticks <= '0;
      end else if (osc_tick && rec_ticks != {push_pull_pkg::OSC_W{1'b1}}) begin
        rec_ticks <= rec_ticks + 1'b1;
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  AST_ALTERNATE: assert property ($rose(gate_drive_first) |-> last_gate)
    else $error("first gate pulsed twice in a row");
  AST_HALF_RATE: assert property (osc_tick && state == push_pull_pkg::ST_RUN
    && !sense.current_limit && !sense.undervoltage_lockout |=> sel != $past(sel))
    else $error("toggle did not advance on an oscillator cycle");
  AST_MARKER_PHASE: assert property (dead_time_marker |-> $past(sense.discharge))
    else $error("marker high outside discharge phase");
  AST_MARKER_IDLE: assert property (state == push_pull_pkg::ST_WAIT
    || state == push_pull_pkg::ST_LOCKOUT |=> !dead_time_marker)
    else $error("marker high while gating inactive");
  AST_OC_KILL: assert property (sense.current_limit |=> !gate_drive_first
    && !gate_drive_second ##1 state == push_pull_pkg::ST_WAIT
    || state == push_pull_pkg::ST_LOCKOUT)
    else $error("gates not shut down on over-current");
  AST_RETRY_WAIT: assert property ($rose(state == push_pull_pkg::ST_MARK)
    |-> rec_ticks == (push_pull_pkg::OSC_W)'(push_pull_pkg::RETRY_CYCLES))
    else $error("retry wait not 56 oscillator cycles");
  AST_START_DELAY: assert property ($rose(state == push_pull_pkg::ST_SOFT)
    |-> rec_ticks == (push_pull_pkg::OSC_W)'(push_pull_pkg::RETRY_CYCLES
                                              + push_pull_pkg::MARK_CYCLES))
    else $error("start delay not 58 cycles before first pulse cycle");
  AST_RECOVERY: assert property ($rose(state == push_pull_pkg::ST_RUN)
    |-> rec_ticks == (push_pull_pkg::OSC_W)'(push_pull_pkg::RECOVERY_CYCLES - 1))
    else $error("recovery not 64 oscillator cycles");
  AST_UNDERVOLTAGE_LOCKOUT_HOLD: assert property (sense.undervoltage_lockout |=> !gate_drive_first
    && !gate_drive_second && !dead_time_marker)
    else $error("outputs active under lockout");
  AST_CHARGE_ONLY: assert property (sense.discharge |=> !gate_drive_first
    && !gate_drive_second)
    else $error("gate driven during discharge");
  AST_MARK_LEADS: assert property ($rose(gate_drive_first || gate_drive_second)
    |-> state == push_pull_pkg::ST_SOFT || state == push_pull_pkg::ST_RUN)
    else $error("gate pulse without preceding marker phase");

  COV_REACH_RUN: cover property ($rose(state == push_pull_pkg::ST_RUN));
  COV_OC_RETRY: cover property (state == push_pull_pkg::ST_RUN && sense.current_limit);
  COV_SECOND: cover property ($rose(gate_drive_second));

endmodule : push_pull_fault_sequencer
`default_nettype wire

// ### osc_load_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Oscillator phase source and gate/marker load observer
// ****************************************************************
module osc_load_model #(
  parameter int CHARGE = 24,
  parameter int DISCH  = 6
) (
  input  wire logic mclk,
  input  wire logic clear,
  input  wire logic gate_drive_first,
  input  wire logic gate_drive_second,
  input  wire logic dead_time_marker,
  output logic      discharge_phase_node
);
  int   phase, ticks, mark_tick, gate_tick, n_first, n_second;
  int   alt_err, overlap, mark_bad, n_pulse, width, mwidth;
  int   widths[8];
  logic rise_first, rise_second, prev_first, prev_second, last_sel;
  bit   gate_seen;

  always @(posedge mclk) begin
    if (clear) begin
      ticks = 0;
      mark_tick = -1;
      gate_tick = -1;
      n_pulse = 0;
      alt_err = 0;
      overlap = 0;
      mark_bad = 0;
    end
    rise_first = gate_drive_first && !prev_first;
    rise_second = gate_drive_second && !prev_second;
    if (rise_first || rise_second) begin
      if (gate_seen && (last_sel == rise_second)) alt_err++;
      last_sel = rise_second;
      gate_seen = 1;
      if (gate_tick < 0) gate_tick = ticks;
      n_first += int'(rise_first);
      n_second += int'(rise_second);
    end
    if (gate_drive_first || gate_drive_second) begin
      width++;
    end else if (width > 0) begin
      if (n_pulse < 8) widths[n_pulse] = width;
      n_pulse++;
      width = 0;
    end
    if (dead_time_marker) begin
      mwidth++;
      if (mark_tick < 0) mark_tick = ticks;
    end else if (mwidth > 0) begin
      if (mwidth != DISCH) mark_bad++;
      mwidth = 0;
    end
    if (dead_time_marker && (gate_drive_first || gate_drive_second)) overlap++;
    prev_first = gate_drive_first;
    prev_second = gate_drive_second;
    // Oscillator advances just after the edge, like any other stimulus
    #1;
    phase = (phase + 1) % (CHARGE + DISCH);
    if (phase == CHARGE) ticks++;
    discharge_phase_node = (phase >= CHARGE);
  end
endmodule : osc_load_model
`default_nettype wire

// ### push_pull_fault_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module push_pull_fault_sequencer_bench;
  localparam int CHARGE = 24;
  localparam int DISCH  = 6;
  // Oscillator tick at which the first marker and the first gate pulse are expected
  localparam int MARK_TICK = push_pull_pkg::RETRY_CYCLES + 1;
  localparam int GATE_TICK = push_pull_pkg::RETRY_CYCLES + push_pull_pkg::MARK_CYCLES;
  logic mclk, reset, current_sense_trip, undervoltage_lockout, clear;
  logic discharge_phase_node, gate_drive_first, gate_drive_second, dead_time_marker;
  int   err_count, comparisons, cycles;

  push_pull_fault_sequencer u_push_pull_fault_sequencer (
    .mclk                 (mclk),
    .reset                (reset),
    .discharge_phase_node (discharge_phase_node),
    .current_sense_trip   (current_sense_trip),
    .undervoltage_lockout (undervoltage_lockout),
    .gate_drive_first     (gate_drive_first),
    .gate_drive_second    (gate_drive_second),
    .dead_time_marker     (dead_time_marker)
  );

  osc_load_model #(.CHARGE(CHARGE), .DISCH(DISCH)) u_osc_load_model (
    .mclk                 (mclk),
    .clear                (clear),
    .gate_drive_first     (gate_drive_first),
    .gate_drive_second    (gate_drive_second),
    .dead_time_marker     (dead_time_marker),
    .discharge_phase_node (discharge_phase_node)
  );

  always #2.5 mclk = ~mclk;

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      $display("[ERR] cycle limit expected below 20000 seen %0d", cycles);
      finish_test();
    end
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step

  task check(input string what, input int exp, input int got);
    comparisons++;
    if (exp != got) begin
      $display("[ERR] %s expected %0d seen %0d", what, exp, got);
      err_count++;
    end
  endtask : check

  task check_outs(input string what, input logic [2:0] exp);
    comparisons++;
    if ({gate_drive_first, gate_drive_second, dead_time_marker} !== exp) begin
      $display("[ERR] %s expected %b seen %b", what, exp,
               {gate_drive_first, gate_drive_second, dead_time_marker});
      err_count++;
    end
  endtask : check_outs

  task wait_ticks(input int n);
    while (u_osc_load_model.ticks < n) step(1);
  endtask : wait_ticks

  task wait_gate;
    while (gate_drive_first === 1'b1 || gate_drive_second === 1'b1) step(1);
    while (gate_drive_first !== 1'b1 && gate_drive_second !== 1'b1) step(1);
    step(2);
  endtask : wait_gate

  // Releases a fault just after an oscillator tick and restarts the tick count
  task release_fault;
    @(posedge discharge_phase_node);
    step(1);
    undervoltage_lockout = 1'b0;
    current_sense_trip = 1'b0;
    clear = 1'b1;
    step(1);
    clear = 1'b0;
  endtask : release_fault

  task check_recovery(input string name);
    int nf;
    int ns;
    int w[8];
    wait_ticks(66);
    w = u_osc_load_model.widths;
    check({name, " marker tick"}, MARK_TICK, u_osc_load_model.mark_tick);
    check({name, " gate tick"}, GATE_TICK, u_osc_load_model.gate_tick);
    for (int i = 0; i < 4; i++) begin
      check({name, " ramp grows"}, 1, int'(w[i] < w[i+1]));
    end
    check({name, " last soft short"}, 1, int'(w[4] < CHARGE));
    check({name, " full width"}, CHARGE, w[5]);
    check({name, " marker width"}, 0, u_osc_load_model.mark_bad);
    check({name, " gate in discharge"}, 0, u_osc_load_model.overlap);
    nf = u_osc_load_model.n_first;
    ns = u_osc_load_model.n_second;
    wait_ticks(86);
    check({name, " first pulses"}, 10, u_osc_load_model.n_first - nf);
    check({name, " second pulses"}, 10, u_osc_load_model.n_second - ns);
    check({name, " alternation"}, 0, u_osc_load_model.alt_err);
  endtask : check_recovery

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task test_startup;
    for (int i = 0; i < 8; i++) begin
      step(17);
      check_outs("lockout outputs", 3'h0);
    end
    release_fault();
    check_recovery("startup");
    $display("test startup done");
  endtask : test_startup

  task test_overcurrent;
    wait_gate();
    current_sense_trip = 1'b1;
    step(4);
    check_outs("trip cuts pulse", 3'h0);
    for (int i = 0; i < 10; i++) begin
      step(13);
      check_outs("trip held outputs", 3'h0);
    end
    release_fault();
    check_recovery("retry");
    $display("test overcurrent done");
  endtask : test_overcurrent

  task test_relock;
    wait_gate();
    undervoltage_lockout = 1'b1;
    step(4);
    check_outs("relock cuts pulse", 3'h0);
    for (int i = 0; i < 6; i++) begin
      step(19);
      check_outs("relock outputs", 3'h0);
    end
    release_fault();
    check_recovery("relock");
    $display("test relock done");
  endtask : test_relock

  task finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  initial begin
    mclk = 1'b0;
    reset = 1'b1;
    undervoltage_lockout = 1'b1;
    current_sense_trip = 1'b0;
    clear = 1'b1;
    err_count = 0;
    comparisons = 0;
    cycles = 0;
    step(4);
    reset = 1'b0;
    clear = 1'b0;
    test_startup();
    test_overcurrent();
    test_relock();
    finish_test();
  end
endmodule : push_pull_fault_sequencer_bench
`default_nettype wire
